// ==== common/dus_uart_map.vh ====
// register map, field positions and reset values of the serial channel
// Summary of operation
// - frames carry eight or nine data bits
// - even, odd or no parity per frame
// - one or two stop bits
// - bit timing from eight-bit baud divisor
// - receiver flags parity, framing, noise, overrun
// - address detect keeps only last-bit-one characters
// - receive buffer holds two characters
// - interrupts on four transmit and receive conditions
// - shared pin activity wakes device when enabled
// - enabled transmitter drives pin, pull-up off
// - cleared enables leave pins floating
// - single-wire select gives half-duplex shared pin
// - single-wire receiver reads the shared pin
// - single-wire transmitter drives the shared pin
// - both enables in single-wire: receiver wins
// - single-wire data optionally mirrored on output pin
// - written data shifts out LSB first
// - received bits shift in LSB first
// - complete character moves into receive buffer
// - one data address, shifters hidden
// - disable flushes buffers, resets flags and divider
`ifndef DUS_UART_MAP_VH
`define DUS_UART_MAP_VH

// register indices
`define DUS_REG_STATUS 3'h0
`define DUS_REG_CTRL1 3'h1
`define DUS_REG_CTRL2 3'h2
`define DUS_REG_CTRL3 3'h3
`define DUS_REG_DATA 3'h4
`define DUS_REG_BAUD 3'h5

// status bits
`define DUS_SR_PERR 7
`define DUS_SR_NF 6
`define DUS_SR_FERR 5
`define DUS_SR_OERR 4
`define DUS_SR_RIDLE 3
`define DUS_SR_RXIF 2
`define DUS_SR_TIDLE 1
`define DUS_SR_TXIF 0

// control one bits
`define DUS_C1_EN 7
`define DUS_C1_NINE 6
`define DUS_C1_PAREN 5
`define DUS_C1_PARODD 4
`define DUS_C1_STOP2 3
`define DUS_C1_BRK 2
`define DUS_C1_RX8 1
`define DUS_C1_TX8 0

// control two bits
`define DUS_C2_TXEN 7
`define DUS_C2_RXEN 6
`define DUS_C2_HIGH 5
`define DUS_C2_ADDEN 4
`define DUS_C2_WAKE 3
`define DUS_C2_RIE 2
`define DUS_C2_TIIE 1
`define DUS_C2_TEIE 0

// control three bits
`define DUS_C3_SWM 0
`define DUS_C3_MIRROR 1

// reset values
`define DUS_RST_CTRL 8'h00
`define DUS_RST_BAUD 8'h00

// oversampling: ticks per bit and centre sample positions
`define DUS_OVS_LAST 4'hf
`define DUS_SMP_A 4'h7
`define DUS_SMP_B 4'h8
`define DUS_SMP_C 4'h9
`define DUS_LOW_PRE 2'h3

`endif

// ==== verilog/dus_baud.v ====
// baud generator: sixteen-times oversampling tick enable
`timescale 1ns/1ps
`include "dus_uart_map.vh"

module dus_baud (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// control
	input wire run,
	input wire high_speed,
	input wire [7:0] divisor,
	// tick
	output reg tick
);

reg [7:0] pre_q;
reg [1:0] low_q;

// tick every divisor+1 clocks, or four times slower in low speed
always @(posedge ref_clk) begin
	if (!nrst || !run) begin
		pre_q <= 8'h00;
		low_q <= 2'h0;
		tick <= 1'b0;
	end else begin
		tick <= 1'b0;
		if (pre_q == divisor) begin
			pre_q <= 8'h00;
			low_q <= low_q + 2'h1;
			if (high_speed || low_q == `DUS_LOW_PRE)
				tick <= 1'b1;
		end else begin
			pre_q <= pre_q + 8'h01;
		end
	end
end

endmodule // dus_baud

// ==== verilog/dus_tx.v ====
// transmit shifter: builds and shifts one frame
`timescale 1ns/1ps
`include "dus_uart_map.vh"

module dus_tx (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// control
	input wire run,
	input wire tick,
	input wire nine,
	input wire par_en,
	input wire par_odd,
	input wire two_stop,
	input wire brk,
	// load strobe with data
	input wire load,
	input wire [8:0] load_data,
	// line side
	output wire line,
	output wire busy
);

reg [11:0] sh_q;
reg [3:0] left_q;
reg [3:0] tcnt_q;

wire p8 = (^load_data[6:0]) ^ par_odd;
wire p9 = (^load_data[7:0]) ^ par_odd;
wire b8 = par_en ? p8 : load_data[7];
wire b9 = par_en ? p9 : load_data[8];
// start low first, then data LSB first, then high stop bits
wire [11:0] f8 = {3'b111, b8, load_data[6:0], 1'b0};
wire [11:0] f9 = {2'b11, b9, load_data[7:0], 1'b0};
wire [3:0] len = 4'h1 + (nine ? 4'h9 : 4'h8) + (two_stop ? 4'h2 : 4'h1);

assign busy = (left_q != 4'h0);
assign line = brk ? 1'b0 : (busy ? sh_q[0] : 1'b1);

always @(posedge ref_clk) begin
	if (!nrst || !run) begin
		sh_q <= 12'hfff;
		left_q <= 4'h0;
		tcnt_q <= 4'h0;
	end else if (load && !busy) begin
		sh_q <= nine ? f9 : f8;
		left_q <= len;
		tcnt_q <= 4'h0;
	end else if (busy && tick) begin
		tcnt_q <= tcnt_q + 4'h1;
		if (tcnt_q == `DUS_OVS_LAST) begin
			sh_q <= {1'b1, sh_q[11:1]};
			left_q <= left_q - 4'h1;
		end
	end
end

endmodule // dus_tx

// ==== verilog/dus_uart.v ====
// serial channel: registers, pins, receiver and receive buffer
`timescale 1ns/1ps
`include "dus_uart_map.vh"

module dus_uart (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// register port
	input wire [2:0] reg_sel,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	// dedicated output pin
	output wire serial_out_pin_o,
	output wire serial_out_pin_oe,
	output wire serial_out_pullup_off,
	// shared pin
	input wire serial_in_shared_pin_i,
	output wire serial_in_shared_pin_o,
	output wire serial_in_shared_pin_oe,
	// events
	output wire irq,
	output wire wake_req
);

localparam RS_IDLE = 4'b0001;
localparam RS_START = 4'b0010;
localparam RS_BITS = 4'b0100;
localparam RS_STOP = 4'b1000;

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] ctrl1_q;
reg [7:0] ctrl2_q;
reg [1:0] ctrl3_q;
reg [7:0] baud_q;
reg tx8_q;
reg perr_q, nf_q, ferr_q, oerr_q;
reg sr_armed_q;

wire en = ctrl1_q[`DUS_C1_EN];
wire nine = ctrl1_q[`DUS_C1_NINE];
wire par_en = ctrl1_q[`DUS_C1_PAREN];
wire par_odd = ctrl1_q[`DUS_C1_PARODD];
wire txen = ctrl2_q[`DUS_C2_TXEN];
wire rxen = ctrl2_q[`DUS_C2_RXEN];
wire swm = ctrl3_q[`DUS_C3_SWM];

wire wr_data = reg_wr && reg_sel == `DUS_REG_DATA;
wire rd_data = reg_rd && reg_sel == `DUS_REG_DATA;
wire rd_stat = reg_rd && reg_sel == `DUS_REG_STATUS;
wire data_acc = wr_data || rd_data;
wire seq_clear = sr_armed_q && data_acc;

// receiver priority over transmitter on the shared pin
wire rx_act = en && rxen;
wire tx_act = en && txen && !(swm && rxen);

////////////////////////////////////////////////////////////////////////
// pin input synchroniser

reg pin_s1_q, pin_s2_q;

always @(posedge ref_clk) begin
	if (!nrst) begin
		pin_s1_q <= 1'b1;
		pin_s2_q <= 1'b1;
	end else begin
		pin_s1_q <= serial_in_shared_pin_i;
		pin_s2_q <= pin_s1_q;
	end
end

// receiver always listens on the shared pin
wire rx_line = pin_s2_q;

////////////////////////////////////////////////////////////////////////
// baud generator and transmitter

wire tick;
wire tx_line;
wire tx_busy;
reg txb_full_q;
reg [8:0] txb_q;
wire tx_load = txb_full_q && !tx_busy && tx_act;

dus_baud u_baud (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.run(en),
	.high_speed(ctrl2_q[`DUS_C2_HIGH]),
	.divisor(baud_q),
	.tick(tick)
);

dus_tx u_tx (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.run(tx_act),
	.tick(tick),
	.nine(nine),
	.par_en(par_en),
	.par_odd(par_odd),
	.two_stop(ctrl1_q[`DUS_C1_STOP2]),
	.brk(ctrl1_q[`DUS_C1_BRK]),
	.load(tx_load),
	.load_data(txb_q),
	.line(tx_line),
	.busy(tx_busy)
);

wire txif = !txb_full_q;
wire tidle = txif && !tx_busy;

////////////////////////////////////////////////////////////////////////
// pin drive

// full duplex: dedicated pin transmits; single wire: shared pin does
assign serial_out_pin_oe = tx_act && (!swm || ctrl3_q[`DUS_C3_MIRROR]);
assign serial_out_pin_o = tx_line;
assign serial_out_pullup_off = tx_act;
assign serial_in_shared_pin_oe = tx_act && swm;
assign serial_in_shared_pin_o = tx_line;

assign wake_req = en && ctrl2_q[`DUS_C2_WAKE] && !rx_line;

////////////////////////////////////////////////////////////////////////
// receiver

reg [3:0] rs_q;
reg [3:0] rcnt_q;
reg [3:0] nbit_q;
reg [8:0] rsh_q;
reg [2:0] smp_q;
reg noise_q;
reg rx_done;
reg rx_ferr;

wire maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) |
	(smp_q[1] & smp_q[2]);
wire disagree = !(&smp_q) && (|smp_q);
wire bit_end = tick && rcnt_q == `DUS_OVS_LAST;
wire [8:0] rx_word = nine ? rsh_q : {1'b0, rsh_q[8:1]};
wire rx_addr = nine ? rx_word[8] : rx_word[7];
wire rx_perr = par_en &&
	((nine ? ^rx_word[8:0] : ^rx_word[7:0]) != par_odd);

always @(posedge ref_clk) begin
	if (!nrst || !rx_act) begin
		rs_q <= RS_IDLE;
		rcnt_q <= 4'h0;
		nbit_q <= 4'h0;
		rsh_q <= 9'h000;
		smp_q <= 3'h0;
		noise_q <= 1'b0;
		rx_done <= 1'b0;
		rx_ferr <= 1'b0;
	end else begin
		rx_done <= 1'b0;
		if (tick) begin
			rcnt_q <= rcnt_q + 4'h1;
			// three samples around the bit centre
			if (rcnt_q == `DUS_SMP_A)
				smp_q[0] <= rx_line;
			if (rcnt_q == `DUS_SMP_B)
				smp_q[1] <= rx_line;
			if (rcnt_q == `DUS_SMP_C)
				smp_q[2] <= rx_line;
		end
		case (rs_q)
		RS_IDLE: begin
			rcnt_q <= 4'h0;
			noise_q <= 1'b0;
			if (!rx_line)
				rs_q <= RS_START;
		end
		RS_START: begin
			if (bit_end) begin
				noise_q <= disagree;
				nbit_q <= nine ? 4'h9 : 4'h8;
				// a high start bit was a glitch
				rs_q <= maj ? RS_IDLE : RS_BITS;
			end
		end
		RS_BITS: begin
			if (bit_end) begin
				rsh_q <= {maj, rsh_q[8:1]};
				noise_q <= noise_q | disagree;
				nbit_q <= nbit_q - 4'h1;
				if (nbit_q == 4'h1)
					rs_q <= RS_STOP;
			end
		end
		RS_STOP: begin
			if (bit_end) begin
				noise_q <= noise_q | disagree;
				rx_ferr <= !maj;
				rx_done <= 1'b1;
				rs_q <= RS_IDLE;
			end
		end
		default: begin
			rs_q <= RS_IDLE;
		end
		endcase
	end
end

wire ridle = rs_q[0];

////////////////////////////////////////////////////////////////////////
// receive buffer, two entries

reg [8:0] fd_q [0:1];
reg [1:0] fcnt_q;
reg wp_q, rp_q;
// address detect drops characters whose last data bit is zero
wire keep = !ctrl2_q[`DUS_C2_ADDEN] || rx_addr;
wire push_req = rx_done && keep;
wire full = fcnt_q[1];
wire push = push_req && !full;
wire pop = rd_data && fcnt_q != 2'h0;
wire rxif = fcnt_q != 2'h0;

always @(posedge ref_clk) begin
	if (!nrst || !en) begin
		fcnt_q <= 2'h0;
		wp_q <= 1'b0;
		rp_q <= 1'b0;
		fd_q[0] <= 9'h000;
		fd_q[1] <= 9'h000;
	end else begin
		if (push) begin
			fd_q[wp_q] <= rx_word;
			wp_q <= !wp_q;
		end
		if (pop)
			rp_q <= !rp_q;
		if (push && !pop)
			fcnt_q <= fcnt_q + 2'h1;
		else if (pop && !push)
			fcnt_q <= fcnt_q - 2'h1;
	end
end

wire [8:0] head = fd_q[rp_q];

////////////////////////////////////////////////////////////////////////
// error flags: status read then data access clears; a new event wins

always @(posedge ref_clk) begin
	if (!nrst || !en) begin
		perr_q <= 1'b0;
		nf_q <= 1'b0;
		ferr_q <= 1'b0;
		oerr_q <= 1'b0;
		sr_armed_q <= 1'b0;
	end else begin
		if (rd_stat)
			sr_armed_q <= 1'b1;
		else if (data_acc)
			sr_armed_q <= 1'b0;
		if (push && rx_perr)
			perr_q <= 1'b1;
		else if (seq_clear)
			perr_q <= 1'b0;
		if (push && noise_q)
			nf_q <= 1'b1;
		else if (seq_clear)
			nf_q <= 1'b0;
		if (push && rx_ferr)
			ferr_q <= 1'b1;
		else if (seq_clear)
			ferr_q <= 1'b0;
		if (push_req && full)
			oerr_q <= 1'b1;
		else if (seq_clear)
			oerr_q <= 1'b0;
	end
end

////////////////////////////////////////////////////////////////////////
// transmit buffer and register writes

always @(posedge ref_clk) begin
	if (!nrst || !tx_act) begin
		txb_full_q <= 1'b0;
		txb_q <= 9'h000;
	end else if (wr_data && !txb_full_q) begin
		txb_q <= {tx8_q, reg_wdata};
		txb_full_q <= 1'b1;
	end else if (tx_load) begin
		txb_full_q <= 1'b0;
	end
end

always @(posedge ref_clk) begin
	if (!nrst) begin
		ctrl1_q <= `DUS_RST_CTRL;
		ctrl2_q <= `DUS_RST_CTRL;
		ctrl3_q <= 2'h0;
		baud_q <= `DUS_RST_BAUD;
		tx8_q <= 1'b0;
	end else begin
		if (reg_wr && reg_sel == `DUS_REG_CTRL1) begin
			ctrl1_q <= {reg_wdata[7:2], 2'h0};
			tx8_q <= reg_wdata[`DUS_C1_TX8];
		end
		if (reg_wr && reg_sel == `DUS_REG_CTRL2)
			ctrl2_q <= reg_wdata;
		if (reg_wr && reg_sel == `DUS_REG_CTRL3)
			ctrl3_q <= reg_wdata[1:0];
		if (reg_wr && reg_sel == `DUS_REG_BAUD)
			baud_q <= reg_wdata;
		// disabled channel drops its enables and break
		if (!en) begin
			ctrl2_q[`DUS_C2_TXEN] <= 1'b0;
			ctrl2_q[`DUS_C2_RXEN] <= 1'b0;
			ctrl1_q[`DUS_C1_BRK] <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// register reads

wire [7:0] status = {perr_q, nf_q, ferr_q, oerr_q, ridle, rxif, tidle,
	txif};

always @(posedge ref_clk) begin
	if (!nrst) begin
		reg_rdata <= 8'h00;
	end else if (reg_rd) begin
		case (reg_sel)
		`DUS_REG_STATUS: reg_rdata <= status;
		`DUS_REG_CTRL1: reg_rdata <= {ctrl1_q[7:2], head[8], 1'b0};
		`DUS_REG_CTRL2: reg_rdata <= ctrl2_q;
		`DUS_REG_CTRL3: reg_rdata <= {6'h00, ctrl3_q};
		`DUS_REG_DATA: reg_rdata <= head[7:0];
		`DUS_REG_BAUD: reg_rdata <= baud_q;
		default: reg_rdata <= 8'h00;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt request

assign irq = en && ((ctrl2_q[`DUS_C2_RIE] && (rxif || oerr_q)) ||
	(ctrl2_q[`DUS_C2_TIIE] && tidle && tx_act) ||
	(ctrl2_q[`DUS_C2_TEIE] && txif && tx_act));

endmodule // dus_uart

// ==== test/dus_uart_props.sv ====
// assertion checker for the serial channel pins and register port
`timescale 1ns/1ps
module dus_uart_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register port
	input wire logic [2:0] reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// pins
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe,
	input wire logic serial_out_pullup_off,
	input wire logic serial_in_shared_pin_i,
	input wire logic serial_in_shared_pin_o,
	input wire logic serial_in_shared_pin_oe,
	// events
	input wire logic wake_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	// shadow of the control registers
	logic [7:0] c1_q, c2_q, c3_q;
	wire en = c1_q[7];
	wire tx = en & c2_q[7];
	wire rx = en & c2_q[6];
	wire sw = c3_q[0];
	always @(posedge ref_clk) begin
		if (!nrst) begin
			c1_q <= 8'h00;
			c2_q <= 8'h00;
			c3_q <= 8'h00;
		end else begin
			if (reg_wr && reg_sel == 3'h1) c1_q <= reg_wdata;
			if (reg_wr && reg_sel == 3'h2) c2_q <= reg_wdata;
			else if (!en) c2_q[7:6] <= 2'h0;
			if (reg_wr && reg_sel == 3'h3) c3_q <= reg_wdata;
		end
	end
	////////////////////////////////////////////////////////////////////////
	float_off_a: assert property (!en |-> !serial_out_pin_oe
		&& !serial_in_shared_pin_oe) else $error("pin driven while off");
	tx_drive_a: assert property (tx && !sw |-> serial_out_pin_oe
		&& serial_out_pullup_off) else $error("output pin not driven");
	fd_shared_a: assert property (!sw |-> !serial_in_shared_pin_oe)
		else $error("shared pin driven in full duplex");
	sw_rx_a: assert property (sw && rx |-> !serial_in_shared_pin_oe)
		else $error("shared pin driven while receiving");
	sw_tx_a: assert property (sw && tx && !rx |-> serial_in_shared_pin_oe)
		else $error("shared pin not driven in single wire send");
	mirror_pin_a: assert property (sw && c3_q[1] && tx && !rx
		|-> serial_out_pin_oe && serial_out_pin_o == serial_in_shared_pin_o)
		else $error("mirror pin differs from shared pin");
	wake_pin_a: assert property ((en && c2_q[3]
		&& !serial_in_shared_pin_i) [*3] |-> wake_req)
		else $error("no wake request");
	unmapped_rd_a: assert property (reg_rd && reg_sel > 3'h5 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	cover property (tx && $fell(serial_out_pin_o));
	cover property (sw && tx && $fell(serial_in_shared_pin_o));
	cover property (wake_req);
endmodule // dus_uart_props

bind dus_uart dus_uart_props i_props (.ref_clk, .nrst, .reg_sel, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata, .serial_out_pin_o, .serial_out_pin_oe,
	.serial_out_pullup_off, .serial_in_shared_pin_i, .serial_in_shared_pin_o,
	.serial_in_shared_pin_oe, .wake_req);

// ==== test/dus_line_dev.sv ====
// line-side model of a remote asynchronous serial device
`timescale 1ns/1ps
module dus_line_dev #(
	parameter int BIT_CLKS = 16
) (
	// clock
	input wire logic ref_clk,
	// watched line and driven line
	input wire logic mon_line,
	output logic drv_val,
	output logic drv_oe
);
	initial begin
		drv_val = 1'b1;
		drv_oe = 1'b0;
	end
	// frame out lsb first, then released to the pull-up
	// gl: index of a bit flipped for one clock near its centre
	task automatic send(input logic [11:0] bits, input int len,
		input int gl = -1);
		@(posedge ref_clk);
		#1;
		drv_oe = 1'b1;
		for (int i = 0; i < len; i++) begin
			drv_val = bits[i];
			if (i == gl) begin
				repeat (BIT_CLKS / 2) @(posedge ref_clk);
				#1 drv_val = ~bits[i];
				@(posedge ref_clk);
				#1 drv_val = bits[i];
				repeat (BIT_CLKS / 2 - 1) @(posedge ref_clk);
			end else begin
				repeat (BIT_CLKS) @(posedge ref_clk);
			end
			#1;
		end
		drv_oe = 1'b0;
		repeat (4) @(posedge ref_clk);
		// step past the edge so callers see the pushed character
		#1;
	endtask
	// frame in: centre sampled from the start edge
	task automatic grab(output logic [11:0] bits, input int len);
		int w;
		bits = 12'hfff;
		w = 0;
		while (mon_line !== 1'b0 && w < 4000) begin
			@(posedge ref_clk);
			w++;
		end
		repeat (BIT_CLKS / 2) @(posedge ref_clk);
		for (int i = 0; i < len; i++) begin
			bits[i] = mon_line;
			repeat (BIT_CLKS) @(posedge ref_clk);
		end
	endtask
endmodule // dus_line_dev

// ==== test/dual_uart_single_wire_tb.sv ====
// self-checking bench of the serial channel
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); \
	end end
module dual_uart_single_wire_tb;
	logic ref_clk = 1'b0, nrst = 1'b0, reg_wr, reg_rd, sw_mon = 1'b0;
	logic [2:0] reg_sel;
	logic [7:0] reg_wdata;
	wire logic [7:0] reg_rdata;
	wire logic out_o, out_oe, sh_o, sh_oe, p_val, p_oe, irq;
	int mismatches = 0, checked = 0, cycles = 0;
	wire sh_wire = sh_oe ? sh_o : (p_oe ? p_val : 1'b1);
	wire out_wire = out_oe ? out_o : 1'b1;
	dus_uart i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_sel(reg_sel),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .serial_out_pin_o(out_o),
		.serial_out_pin_oe(out_oe), .serial_out_pullup_off(),
		.serial_in_shared_pin_i(sh_wire), .serial_in_shared_pin_o(sh_o),
		.serial_in_shared_pin_oe(sh_oe), .irq(irq), .wake_req());
	dus_line_dev i_dev (.ref_clk(ref_clk),
		.mon_line(sw_mon ? sh_wire : out_wire),
		.drv_val(p_val), .drv_oe(p_oe));
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [2:0] s, input logic [7:0] d);
		@(posedge ref_clk);
		#1 {reg_sel, reg_wdata, reg_wr} = {s, d, 1'b1};
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [2:0] s, output logic [7:0] d);
		@(posedge ref_clk);
		#1 {reg_sel, reg_rd} = {s, 1'b1};
		@(posedge ref_clk);
		#1 reg_rd = 1'b0;
		d = reg_rdata;
	endtask
	// c: nine bits, parity, odd, two stops
	function automatic logic [11:0] frame(input logic [8:0] d,
		input logic [3:0] c);
		int n;
		logic [11:0] f;
		n = c[3] ? 9 : 8;
		f = 12'hfff;
		f[0] = 1'b0;
		for (int i = 0; i < n; i++) f[i + 1] = d[i];
		if (c[2]) f[n] = ^(d & ~(9'h1ff << (n - 1))) ^ c[1];
		return f;
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] d;
		rd(3'h0, d); `CHK(d, 8'h0b)
		for (int s = 1; s < 8; s++) begin
			rd(s[2:0], d);
			if (s != 4) `CHK(d, 8'h00)
		end
	endtask
	task automatic t_tx();
		logic [3:0] cf [4] = '{4'h4, 4'h6, 4'he, 4'h9};
		logic [11:0] b;
		logic [7:0] d;
		for (int k = 0; k < 4; k++) begin
			wr(3'h1, {1'b1, cf[k], 3'h1});
			wr(3'h2, 8'ha0);
			wr(3'h4, 8'h5a + k[7:0]);
			i_dev.grab(b, 10 + cf[k][3] + cf[k][0]);
			`CHK(b, frame({1'b1, 8'h5a + k[7:0]}, cf[k]))
		end
		wr(3'h4, 8'h33);
		wr(3'h1, 8'h00);
		rd(3'h0, d); `CHK(d, 8'h0b)
		rd(3'h2, d); `CHK(d, 8'h20)
	endtask
	task automatic t_rx();
		logic [7:0] d;
		wr(3'h1, 8'ha0);
		wr(3'h2, 8'h68);
		i_dev.send(frame(9'h35, 4'h4), 10);
		i_dev.send(frame(9'h4a, 4'h4) ^ 12'h100, 10);
		i_dev.send(frame(9'h21, 4'h4), 10);
		rd(3'h0, d); `CHK(d & 8'hfc, 8'h9c)
		rd(3'h4, d); `CHK(d & 8'h7f, 8'h35)
		rd(3'h4, d); `CHK(d & 8'h7f, 8'h4a)
		rd(3'h0, d); `CHK(d & 8'hfc, 8'h08)
		wr(3'h1, 8'h80);
		wr(3'h2, 8'h74);
		i_dev.send(frame(9'h12, 4'h0), 10);
		i_dev.send(frame(9'h93, 4'h0), 10);
		`CHK(irq, 1'b1)
		rd(3'h0, d);
		rd(3'h4, d); `CHK(d, 8'h93)
		rd(3'h0, d); `CHK(d & 8'h04, 8'h00)
		`CHK(irq, 1'b0)
	endtask
	task automatic t_sw();
		logic [11:0] b;
		logic [7:0] d;
		wr(3'h3, 8'h03);
		wr(3'h2, 8'ha0);
		sw_mon = 1'b1;
		wr(3'h4, 8'hc3);
		i_dev.grab(b, 10);
		`CHK(b, frame(9'h0c3, 4'h0))
		wr(3'h2, 8'he0);
		i_dev.send(frame(9'h5e, 4'h0), 10);
		rd(3'h4, d); `CHK(d, 8'h5e)
	endtask
	// nine bits with odd parity: one noisy frame, one with a low stop bit
	task automatic t_errs();
		logic [7:0] d;
		wr(3'h3, 8'h00);
		sw_mon = 1'b0;
		wr(3'h1, 8'hf0);
		wr(3'h2, 8'h60);
		i_dev.send(frame(9'h05a, 4'he), 11, 3);
		i_dev.send(frame(9'h0c3, 4'he) ^ 12'h400, 11);
		rd(3'h1, d);
		`CHK(d, 8'hf2)
		rd(3'h0, d);
		`CHK(d & 8'hfc, 8'h6c)
		rd(3'h4, d);
		`CHK(d, 8'h5a)
		rd(3'h4, d);
		`CHK(d, 8'hc3)
		rd(3'h0, d);
		`CHK(d & 8'hfc, 8'h08)
	endtask
	// low speed, divisor one: 4 * 2 clocks a tick, 128 clocks a bit
	task automatic t_slow();
		logic [7:0] d;
		int n;
		wr(3'h1, 8'h80);
		wr(3'h5, 8'h01);
		wr(3'h2, 8'h83);
		`CHK(irq, 1'b1)
		wr(3'h4, 8'h0e);
		`CHK(irq, 1'b0)
		while (out_wire !== 1'b0) @(posedge ref_clk);
		while (out_wire !== 1'b1) @(posedge ref_clk);
		n = 0;
		while (out_wire === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(n, 384)
		rd(3'h0, d);
		`CHK(d & 8'h03, 8'h01)
		repeat (700) @(posedge ref_clk);
		`CHK(out_wire, 1'b1)
		wr(3'h1, 8'h84);
		`CHK(out_wire, 1'b0)
		wr(3'h1, 8'h00);
		`CHK(out_oe, 1'b0)
	endtask
	initial begin
		{reg_sel, reg_wdata, reg_wr, reg_rd} = '0;
		repeat (8) @(posedge ref_clk);
		#1 nrst = 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_sw();
		t_errs();
		t_slow();
		give_verdict();
	end
endmodule // dual_uart_single_wire_tb
